// >>> hgc_pkg.sv
// Shared constants and carrier types of the H-bridge gate control block
package hgc_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_NS = 4;
   localparam int CLR_MIN_NS = 3100;
   localparam int CLR_MAX_NS = 3600;
   localparam int SHUT_NS = 7000;
   localparam int DEAD_NS = 20;
   // Least times round up, longest times round down
   localparam int CLR_MIN_CYC = (CLR_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CLR_MAX_CYC = CLR_MAX_NS / CLK_NS;
   localparam int SHUT_CYC = (SHUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PIN_CNT_W = 11;
   localparam int GAP_W = 8;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;
   localparam logic [3:0] ADDR_STATE = 4'hC;
   localparam int EV_W = 4;
   localparam int EV_UV = 0;
   localparam int EV_SC = 1;
   localparam int EV_OT = 2;
   localparam int EV_SHUT = 3;
   localparam int CTRL_W = 16;
   localparam int BE_DIS = 0;
   localparam int BE_GAP = 1;
   localparam logic [GAP_W-1:0] GAP_RST = GAP_W'(DEAD_CYC);

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic upper;
      logic lower;
   } hgc_half_type;

   typedef hgc_half_type [1:0] hgc_bridge_type;

   typedef struct packed {
      logic [GAP_W-1:0] gap;
      logic [6:0] rsvd;
      logic dis;
   } hgc_ctrl_type;

   typedef struct packed {
      logic shut_pin_n;
      logic cause_pin_n;
      logic off_all;
      logic ot;
      logic [1:0] uv;
      logic [1:0] sc_latch;
      hgc_bridge_type gates;
   } hgc_state_type;

endpackage

// >>> hgc_pin_filter.sv
// Duration filter on the gap and shutoff pin: diagnosis clear and shutdown
`timescale 1ns/1ps
module hgc_pin_filter (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic pin_high_in,
   output logic shut_out,
   output logic clear_out
);
   localparam logic [hgc_pkg::PIN_CNT_W-1:0] MIN_C = hgc_pkg::PIN_CNT_W'(hgc_pkg::CLR_MIN_CYC);
   localparam logic [hgc_pkg::PIN_CNT_W-1:0] MAX_C = hgc_pkg::PIN_CNT_W'(hgc_pkg::CLR_MAX_CYC);
   localparam logic [hgc_pkg::PIN_CNT_W-1:0] SHUT_C = hgc_pkg::PIN_CNT_W'(hgc_pkg::SHUT_CYC);

   logic [hgc_pkg::PIN_CNT_W-1:0] cnt;
   logic [hgc_pkg::PIN_CNT_W-1:0] next_cnt;
   logic next_shut;
   logic next_clear;

   always_comb begin
      next_cnt = cnt;
      next_shut = shut_out;
      next_clear = 1'b0;
      if (pin_high_in) begin
         if (cnt < SHUT_C) begin
            next_cnt = cnt + 1'b1;
         end
         next_shut = (next_cnt == SHUT_C);
      end else begin
         next_cnt = '0;
         next_shut = 1'b0;
         if (((cnt >= MIN_C) && (cnt <= MAX_C)) || (cnt == SHUT_C)) begin
            next_clear = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cnt <= '0;
         shut_out <= 1'b0;
         clear_out <= 1'b0;
      end else begin
         cnt <= next_cnt;
         shut_out <= next_shut;
         clear_out <= next_clear;
      end
   end

   a_clear_window: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!pin_high_in && $past(pin_high_in) && cnt >= MIN_C && cnt <= MAX_C) |=> clear_out)
      else $error("window pulse did not clear diagnosis");
   a_shut_long: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (pin_high_in && cnt == SHUT_C - 1'b1) |=> shut_out)
      else $error("long high on shutoff pin did not shut down");

endmodule // hgc_pin_filter

// >>> hgc_gap_timer.sv
// Non-overlap timer for the two gates of one half-bridge
`timescale 1ns/1ps
module hgc_gap_timer (
   input wire logic clk_in,
   input wire logic nrst_in,
   input hgc_pkg::hgc_half_type target_in,
   input wire logic [hgc_pkg::GAP_W-1:0] gap_in,
   output hgc_pkg::hgc_half_type gate_out
);
   logic [hgc_pkg::GAP_W-1:0] cnt;
   logic [hgc_pkg::GAP_W-1:0] next_cnt;
   hgc_pkg::hgc_half_type next_gate;
   logic off_needed;

   always_comb begin
      next_gate = gate_out;
      next_cnt = '0;
      off_needed = |(gate_out & ~target_in);
      if (off_needed) begin
         next_gate = gate_out & target_in;
      end else if (gate_out != target_in) begin
         if (cnt >= gap_in) begin
            next_gate = target_in;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cnt <= '0;
         gate_out <= '0;
      end else begin
         cnt <= next_cnt;
         gate_out <= next_gate;
      end
   end

   a_never_both: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !(gate_out.upper && gate_out.lower))
      else $error("both gates of a half-bridge on");
   a_lower_gap: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $rose(gate_out.lower) |-> !$past(gate_out.upper))
      else $error("lower gate on without off interval");

endmodule // hgc_gap_timer

// >>> hgc_top.sv
// Gate control logic of an H-bridge driver with Avalon-MM registers
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module hgc_top (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic dir_in,
   input wire logic pwm_in,
   input wire logic gap_and_shutoff_pin_in,
   input wire logic [1:0] supply_low_fault_in,
   input wire logic [1:0] overcurrent_fault_in,
   input wire logic overheat_warning_in,
   input wire logic shutdown_flag_n_in,
   output logic shutdown_flag_n_out,
   output logic shutdown_flag_n_oe_n_out,
   input wire logic cause_warning_flag_n_in,
   output logic cause_warning_flag_n_out,
   output logic cause_warning_flag_n_oe_n_out,
   output logic upper_gate_a_out,
   output logic lower_gate_a_out,
   output logic upper_gate_b_out,
   output logic lower_gate_b_out,
   input wire logic [hgc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq_out
);
   // ==========================================================
   // Pin filter and gap timers
   // ==========================================================
   logic pin_shut;
   logic diag_clear;
   hgc_pkg::hgc_bridge_type target;
   hgc_pkg::hgc_bridge_type gates;
   hgc_pkg::hgc_ctrl_type ctrl;

   hgc_pin_filter u_pin_filter (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .pin_high_in(gap_and_shutoff_pin_in),
      .shut_out(pin_shut),
      .clear_out(diag_clear)
   );

   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_half
         hgc_gap_timer u_gap (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .target_in(target[h]),
            .gap_in(ctrl.gap),
            .gate_out(gates[h])
         );
      end
   endgenerate

   assign upper_gate_a_out = gates[0].upper;
   assign lower_gate_a_out = gates[0].lower;
   assign upper_gate_b_out = gates[1].upper;
   assign lower_gate_b_out = gates[1].lower;

   // ==========================================================
   // Gate mapping and fault handling
   // ==========================================================
   hgc_pkg::hgc_bridge_type demand;
   logic [1:0] sc_latch;
   logic [1:0] next_sc_latch;
   logic [1:0] affected;
   logic off_all;
   logic shut_n;
   logic cause_n;
   logic next_shut_n;
   logic next_cause_n;
   logic pull_level;

   always_comb begin
      if (pwm_in) begin
         demand[0] = dir_in ? 2'b01 : 2'b10;
         demand[1] = dir_in ? 2'b10 : 2'b01;
      end else begin
         demand[0] = 2'b10;
         demand[1] = 2'b10;
      end
      off_all = pin_shut | ctrl.dis;
      next_sc_latch = (diag_clear ? 2'b00 : sc_latch) | overcurrent_fault_in;
      affected = supply_low_fault_in | sc_latch;
      for (int i = 0; i < 2; i++) begin
         target[i] = (off_all || affected[i]) ? 2'b00 : demand[i];
      end
      next_shut_n = off_all || (target == demand);
      next_cause_n = off_all || !((|supply_low_fault_in) || overheat_warning_in);
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         sc_latch <= 2'b00;
         shut_n <= 1'b1;
         cause_n <= 1'b1;
         pull_level <= 1'b0;
      end else begin
         sc_latch <= next_sc_latch;
         shut_n <= next_shut_n;
         cause_n <= next_cause_n;
         pull_level <= 1'b0;
      end
   end

   // Open-drain flags: pull low by enabling the driver
   assign shutdown_flag_n_out = pull_level;
   assign shutdown_flag_n_oe_n_out = shut_n;
   assign cause_warning_flag_n_out = pull_level;
   assign cause_warning_flag_n_oe_n_out = cause_n;

   // ==========================================================
   // Events, status and interrupt
   // ==========================================================
   logic [hgc_pkg::EV_W-1:0] status;
   logic [hgc_pkg::EV_W-1:0] mask;
   logic [hgc_pkg::EV_W-1:0] next_status;
   logic [hgc_pkg::EV_W-1:0] next_mask;
   logic [hgc_pkg::EV_W-1:0] events;
   logic [hgc_pkg::EV_W-1:0] w1c;
   logic [1:0] prev_uv;
   logic prev_ot;
   logic prev_shut;
   logic next_irq;

   always_comb begin
      events = '0;
      events[hgc_pkg::EV_UV] = |(supply_low_fault_in & ~prev_uv);
      events[hgc_pkg::EV_SC] = |(overcurrent_fault_in & ~sc_latch);
      events[hgc_pkg::EV_OT] = overheat_warning_in & ~prev_ot;
      events[hgc_pkg::EV_SHUT] = pin_shut & ~prev_shut;
      // Set wins over a simultaneous clear
      next_status = (status & ~w1c) | events;
      next_irq = |(status & mask);
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         status <= '0;
         prev_uv <= 2'b00;
         prev_ot <= 1'b0;
         prev_shut <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         status <= next_status;
         prev_uv <= supply_low_fault_in;
         prev_ot <= overheat_warning_in;
         prev_shut <= pin_shut;
         irq_out <= next_irq;
      end
   end

   // ==========================================================
   // Avalon-MM slave
   // ==========================================================
   hgc_pkg::hgc_ctrl_type next_ctrl;
   hgc_pkg::hgc_ctrl_type wr_ctrl;
   hgc_pkg::hgc_state_type state;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic wr_go;

   always_comb begin
      state.shut_pin_n = shutdown_flag_n_in;
      state.cause_pin_n = cause_warning_flag_n_in;
      state.off_all = off_all;
      state.ot = overheat_warning_in;
      state.uv = supply_low_fault_in;
      state.sc_latch = sc_latch;
      state.gates = gates;
      wr_go = avs_write && !avs_waitrequest;
      wr_ctrl = hgc_pkg::hgc_ctrl_type'(avs_writedata[hgc_pkg::CTRL_W-1:0]);
      next_ctrl = ctrl;
      next_mask = mask;
      w1c = '0;
      next_readdata = avs_readdata;
      next_waitrequest = 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
         next_waitrequest = 1'b0;
      end
      if (avs_read && avs_waitrequest) begin
         if (avs_address == hgc_pkg::ADDR_CTRL) begin
            next_readdata = 32'(ctrl);
         end else if (avs_address == hgc_pkg::ADDR_STATUS) begin
            next_readdata = 32'(status);
         end else if (avs_address == hgc_pkg::ADDR_MASK) begin
            next_readdata = 32'(mask);
         end else if (avs_address == hgc_pkg::ADDR_STATE) begin
            next_readdata = 32'(state);
         end else begin
            next_readdata = 32'h0000_0000;
         end
      end
      if (wr_go) begin
         if (avs_address == hgc_pkg::ADDR_CTRL) begin
            if (avs_byteenable[hgc_pkg::BE_DIS]) begin
               next_ctrl.dis = wr_ctrl.dis;
            end
            if (avs_byteenable[hgc_pkg::BE_GAP]) begin
               next_ctrl.gap = wr_ctrl.gap;
            end
         end else if (avs_address == hgc_pkg::ADDR_STATUS) begin
            if (avs_byteenable[0]) begin
               w1c = avs_writedata[hgc_pkg::EV_W-1:0];
            end
         end else if (avs_address == hgc_pkg::ADDR_MASK) begin
            if (avs_byteenable[0]) begin
               next_mask = avs_writedata[hgc_pkg::EV_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ctrl <= '{gap: hgc_pkg::GAP_RST, rsvd: 7'h00, dis: 1'b0};
         mask <= '0;
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   logic run_ok;
   assign run_ok = !off_all && (sc_latch == 2'b00) && (supply_low_fault_in == 2'b00)
      && (ctrl.gap <= hgc_pkg::GAP_RST);

   sequence s_fwd;
      (pwm_in && !dir_in && run_ok) [*8];
   endsequence
   sequence s_rev;
      (pwm_in && dir_in && run_ok) [*8];
   endsequence
   sequence s_brake;
      (!pwm_in && run_ok) [*8];
   endsequence

   a_map_forward: assert property (s_fwd |-> upper_gate_a_out && lower_gate_b_out)
      else $error("forward mapping wrong");
   a_map_reverse: assert property (s_rev |-> lower_gate_a_out && upper_gate_b_out)
      else $error("reverse mapping wrong");
   a_map_brake: assert property (s_brake |-> upper_gate_a_out && upper_gate_b_out
      && !lower_gate_a_out && !lower_gate_b_out)
      else $error("PWM low mapping wrong");
   a_uv_gate_off: assert property (supply_low_fault_in[0]
      |=> !upper_gate_a_out && !lower_gate_a_out)
      else $error("undervoltage gate not forced low");
   a_uv_flags: assert property ((supply_low_fault_in != 2'b00) && !off_all
      |=> !shutdown_flag_n_oe_n_out && !cause_warning_flag_n_oe_n_out)
      else $error("undervoltage flag pattern wrong");
   a_sc_hold: assert property (sc_latch[0] && !diag_clear
      |=> sc_latch[0] && !upper_gate_a_out && !lower_gate_a_out)
      else $error("overcurrent latch released early");
   a_bridge_float: assert property (sc_latch[1]
      |=> !upper_gate_b_out && !lower_gate_b_out)
      else $error("overcurrent half-bridge not floating");
   a_sc_flags: assert property ((sc_latch != 2'b00) && (supply_low_fault_in == 2'b00)
      && !overheat_warning_in && !off_all
      |=> !shutdown_flag_n_oe_n_out && cause_warning_flag_n_oe_n_out)
      else $error("overcurrent flag pattern wrong");
   a_ot_flags: assert property (overheat_warning_in && (sc_latch == 2'b00)
      && (supply_low_fault_in == 2'b00) && !off_all
      |=> shutdown_flag_n_oe_n_out && !cause_warning_flag_n_oe_n_out)
      else $error("overheat flag pattern wrong");
   a_match_release: assert property ((target == demand) && !off_all
      |=> shutdown_flag_n_oe_n_out)
      else $error("shutdown flag low with matching outputs");
   a_pin_shut_all: assert property (pin_shut |=> !upper_gate_a_out && !lower_gate_a_out
      && !upper_gate_b_out && !lower_gate_b_out
      && shutdown_flag_n_oe_n_out && cause_warning_flag_n_oe_n_out)
      else $error("pin shutdown not complete");
   a_clear_latch: assert property (diag_clear && (overcurrent_fault_in == 2'b00)
      |=> sc_latch == 2'b00)
      else $error("diagnosis clear ignored");

endmodule // hgc_top

// >>> hgc_mcu_model.sv
// Controller model that drives the direction and PWM inputs
`timescale 1ns/1ps
module hgc_mcu_model (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic fast_in,
   input wire logic dir_set_in,
   input wire logic pwm_set_in,
   output logic dir_out,
   output logic pwm_out
);
   logic [5:0] tick;

   // ==========================================================
   // Pattern source
   // ==========================================================
   // fast decay pattern
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tick <= 6'h00;
         dir_out <= 1'h0;
         pwm_out <= 1'h0;
      end else if (fast_in) begin
         tick <= tick + 6'h01;
         pwm_out <= 1'h1;
         if (tick == 6'h27) begin
            tick <= 6'h00;
            dir_out <= !dir_out;
         end
      end else begin
         tick <= 6'h00;
         dir_out <= dir_set_in;
         pwm_out <= pwm_set_in;
      end
   end
endmodule // hgc_mcu_model

// >>> tb_hgc_top.sv
// Self-checking testbench of the H-bridge gate control block
`timescale 1ns/1ps
module tb_hgc_top;
   logic clk_in = 1'h0;
   logic nrst_in = 1'h0;
   logic fast = 1'h0;
   logic dir_set = 1'h0;
   logic pwm_set = 1'h0;
   logic dir;
   logic pwm;
   logic pin = 1'h0;
   logic [1:0] uv = 2'h0;
   logic [1:0] sc = 2'h0;
   logic ot = 1'h0;
   logic shut_d;
   logic shut_oe_n;
   logic cause_d;
   logic cause_oe_n;
   logic ua;
   logic la;
   logic ub;
   logic lb;
   logic irq;
   logic wreq;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] rdata;
   logic [31:0] rd;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int overlaps = 0;
   // Open-drain flags with pull-ups
   wire logic shut_w = shut_oe_n ? 1'h1 : shut_d;
   wire logic cause_w = cause_oe_n ? 1'h1 : cause_d;
   wire logic [31:0] gates = {28'h0, ua, la, ub, lb};
   wire logic [31:0] flags = {30'h0, shut_w, cause_w};

   always #2 clk_in = !clk_in;

   hgc_mcu_model hgc_mcu_model_inst (.clk_in(clk_in), .nrst_in(nrst_in), .fast_in(fast),
      .dir_set_in(dir_set), .pwm_set_in(pwm_set), .dir_out(dir), .pwm_out(pwm));

   hgc_top hgc_top_inst (.clk_in(clk_in), .nrst_in(nrst_in), .dir_in(dir), .pwm_in(pwm),
      .gap_and_shutoff_pin_in(pin), .supply_low_fault_in(uv), .overcurrent_fault_in(sc),
      .overheat_warning_in(ot), .shutdown_flag_n_in(shut_w), .shutdown_flag_n_out(shut_d),
      .shutdown_flag_n_oe_n_out(shut_oe_n), .cause_warning_flag_n_in(cause_w),
      .cause_warning_flag_n_out(cause_d), .cause_warning_flag_n_oe_n_out(cause_oe_n),
      .upper_gate_a_out(ua), .lower_gate_a_out(la), .upper_gate_b_out(ub),
      .lower_gate_b_out(lb), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .irq_out(irq));

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (nrst_in && ((ua && la) || (ub && lb))) begin
         overlaps++;
      end
      if (cycles == 10000) begin
         fail_count++;
         $display("[ERR] run time expected below 10000 cycles seen %0d", cycles);
         complete_run;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Held until waitrequest is sampled low, one idle edge after
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_in);
      end while (wreq !== 1'h0);
      rd = rdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      cyc(1);
   endtask

   function automatic logic [31:0] want(input logic d, input logic p);
      return p ? (d ? 32'h6 : 32'h9) : 32'hA;
   endfunction

   task automatic drive(input logic d, input logic p);
      dir_set <= d;
      pwm_set <= p;
      cyc(16);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs;
      bus(1'h0, hgc_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'h00000500, rd);
      bus(1'h0, hgc_pkg::ADDR_STATUS, 32'h0);
      chk("status reset", 32'h0, rd);
      bus(1'h1, hgc_pkg::ADDR_MASK, 32'hF);
      bus(1'h0, hgc_pkg::ADDR_MASK, 32'h0);
      chk("mask rw", 32'hF, rd);
      bus(1'h1, hgc_pkg::ADDR_MASK, 32'h0);
      bus(1'h0, 4'h2, 32'h0);
      chk("unmapped read", 32'h0, rd);
      bus(1'h1, hgc_pkg::ADDR_CTRL, 32'h00000501);
      cyc(2);
      chk("gates soft off", 32'h0, gates);
      chk("flags soft off", 32'h3, flags);
      bus(1'h0, hgc_pkg::ADDR_STATE, 32'h0);
      chk("state soft off", 32'h00000E00, rd);
      avs_byteenable <= 4'h2;
      bus(1'h1, hgc_pkg::ADDR_CTRL, 32'h00000300);
      avs_byteenable <= 4'hF;
      bus(1'h0, hgc_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl lane write", 32'h00000301, rd);
      bus(1'h1, hgc_pkg::ADDR_CTRL, 32'h00000500);
      $display("test regs done");
   endtask

   task automatic t_map;
      for (int i = 0; i < 4; i++) begin
         drive(i[1], i[0]);
         chk("gates map", want(i[1], i[0]), gates);
         chk("flags map", 32'h3, flags);
      end
      $display("test map done");
   endtask

   task automatic t_uv;
      uv <= 2'h1;
      drive(1'h0, 1'h1);
      chk("gates uv a", 32'h1, gates);
      chk("flags uv", 32'h0, flags);
      uv <= 2'h2;
      cyc(16);
      chk("gates uv b", 32'h8, gates);
      uv <= 2'h0;
      cyc(16);
      chk("gates uv end", 32'h9, gates);
      chk("flags uv end", 32'h3, flags);
      $display("test uv done");
   endtask

   task automatic t_ot;
      ot <= 1'h1;
      drive(1'h1, 1'h0);
      chk("gates ot", 32'hA, gates);
      chk("flags ot", 32'h2, flags);
      ot <= 1'h0;
      cyc(4);
      $display("test ot done");
   endtask

   task automatic t_sc;
      drive(1'h0, 1'h1);
      sc <= 2'h2;
      cyc(3);
      sc <= 2'h0;
      cyc(16);
      chk("gates sc", 32'h8, gates);
      chk("flags sc", 32'h1, flags);
      drive(1'h1, 1'h1);
      chk("gates sc latched", 32'h4, gates);
      pin <= 1'h1;
      cyc(1000);
      pin <= 1'h0;
      cyc(16);
      chk("gates long pulse", 32'h4, gates);
      pin <= 1'h1;
      cyc(790);
      chk("gates during clear", 32'h4, gates);
      cyc(10);
      pin <= 1'h0;
      cyc(16);
      chk("gates cleared", 32'h6, gates);
      chk("flags cleared", 32'h3, flags);
      $display("test sc done");
   endtask

   task automatic t_shut;
      ot <= 1'h1;
      uv <= 2'h1;
      drive(1'h0, 1'h1);
      pin <= 1'h1;
      cyc(1790);
      chk("gates shutoff", 32'h0, gates);
      chk("flags shutoff", 32'h3, flags);
      ot <= 1'h0;
      uv <= 2'h0;
      pin <= 1'h0;
      cyc(16);
      chk("gates resume", 32'h9, gates);
      $display("test shut done");
   endtask

   task automatic t_decay;
      fast <= 1'h1;
      cyc(400);
      fast <= 1'h0;
      cyc(16);
      chk("overlap count", 32'h0, overlaps);
      $display("test decay done");
   endtask

   task automatic t_irq;
      bus(1'h1, hgc_pkg::ADDR_STATUS, 32'hF);
      bus(1'h1, hgc_pkg::ADDR_MASK, 32'h2);
      bus(1'h0, hgc_pkg::ADDR_STATUS, 32'h0);
      chk("status cleared", 32'h0, rd);
      chk("irq idle", 32'h0, {31'h0, irq});
      ot <= 1'h1;
      cyc(4);
      ot <= 1'h0;
      cyc(4);
      chk("irq masked", 32'h0, {31'h0, irq});
      sc <= 2'h1;
      cyc(3);
      sc <= 2'h0;
      cyc(4);
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(1'h0, hgc_pkg::ADDR_STATUS, 32'h0);
      chk("status events", 32'h6, rd);
      bus(1'h1, hgc_pkg::ADDR_STATUS, 32'h2);
      cyc(3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      bus(1'h0, hgc_pkg::ADDR_STATUS, 32'h0);
      chk("status w1c", 32'h4, rd);
      $display("test irq done");
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'h1;
      cyc(2);
      t_regs;
      t_map;
      t_uv;
      t_ot;
      t_sc;
      t_shut;
      t_decay;
      t_irq;
      complete_run;
   end
endmodule // tb_hgc_top
